// ### core/lvd_cfg.svh
// Purpose: register map, field positions and reset values of the low voltage monitor
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: definitions only
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define LVD_OFF_CTRL 8'h00
`define LVD_OFF_STATUS 8'h04
`define LVD_OFF_CLEAR 8'h08
`define LVD_OFF_IRQ_EN 8'h0C
`define LVD_OFF_CORE 8'h10

// ****************************************
// control register fields
// ****************************************
`define LVD_TRIP_LSB 0
`define LVD_TRIP_MSB 3
`define LVD_PWR_BIT 4
`define LVD_STABLE_BIT 5
`define LVD_CTRL_RESET 5'h05
`define LVD_CODE_EXT 4'hF
`define LVD_CODE_RSVD 4'h0

// ****************************************
// event bits (status, clear, enable)
// ****************************************
`define LVD_EV_LOW 0
`define LVD_EV_STABLE 1
`define LVD_EV_W 2

// ****************************************
// core control register fields
// ****************************************
`define LVD_GIE_BIT 0

// ****************************************
// bus responses
// ****************************************
`define LVD_RESP_OKAY 2'h0
`define LVD_RESP_SLVERR 2'h2

`endif

// ### core/lvd_pkg.sv
// Purpose: types shared by the low voltage monitor control logic
// Assumes: nothing
// Notes: constants live in lvd_cfg.svh
package lvd_pkg;

  // monitor state, one-hot
  typedef enum logic [2:0]
  {
    ST_OFF = 3'b001,
    ST_SETTLE = 3'b010,
    ST_ARMED = 3'b100
  } mon_state_t;

  // drive toward the analog comparator, divider and input mux
  typedef struct packed
  {
    logic power_en;
    logic ext_sel;
    logic [14:0] tap_sel;
  } analog_ctrl_t;

  // raw asynchronous indications from the analog side
  typedef struct packed
  {
    logic supply_low;
    logic ref_stable;
    logic bor_ref_on;
  } analog_sense_t;

endpackage

// ### core/low_voltage_detect_control.sv
// Purpose: control logic of the on-chip low voltage monitor behind an AXI4-Lite slave
// Assumes: analog sense signals are asynchronous; sleep_mode comes from the core on aclk
// Notes: one-hot monitor state; sticky events with write-one clear and enable gating
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "lvd_cfg.svh"

module low_voltage_detect_control #(
  parameter int ADDR_W = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire lvd_pkg::analog_sense_t sense,
  output lvd_pkg::analog_ctrl_t analog_ctrl,
  input wire logic sleep_mode,
  output logic irq,
  output logic wake_request,
  output logic vector_branch
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the offset decode reads address bits 7:2
  if (ADDR_W < 8)
  begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  // ****************************************
  // functions
  // ****************************************
  function automatic lvd_pkg::analog_ctrl_t decode_ctrl(input logic [4:0] c);
    lvd_pkg::analog_ctrl_t r;
    r = '0;
    r.power_en = c[`LVD_PWR_BIT];
    if (c[`LVD_TRIP_MSB:`LVD_TRIP_LSB] == `LVD_CODE_EXT)
    begin
      r.ext_sel = 1'b1;
    end
    else if (c[`LVD_TRIP_MSB:`LVD_TRIP_LSB] != `LVD_CODE_RSVD)
    begin
      r.tap_sel = 15'h0001 << c[`LVD_TRIP_MSB:`LVD_TRIP_LSB];
    end
    return r;
  endfunction

  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
    return {a[7:2], 2'b00};
  endfunction

  // ****************************************
  // synchronisers
  // ****************************************
  logic [2:0] sense_s1_q;
  logic [2:0] sense_s2_q;
  logic low_s2;
  logic ref_s2;
  logic bor_s2;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sense_s1_q <= 3'h0;
      sense_s2_q <= 3'h0;
    end
    else
    begin
      sense_s1_q <= sense;
      sense_s2_q <= sense_s1_q;
    end
  end

  assign low_s2 = sense_s2_q[2];
  assign ref_s2 = sense_s2_q[1];
  assign bor_s2 = sense_s2_q[0];

  // ****************************************
  // register state
  // ****************************************
  logic [4:0] ctrl_q, ctrl_d;
  logic [`LVD_EV_W-1:0] status_q, status_d;
  logic [`LVD_EV_W-1:0] irq_en_q, irq_en_d;
  logic gie_q, gie_d;
  lvd_pkg::mon_state_t state_q, state_d;
  lvd_pkg::analog_ctrl_t actl_q, actl_d;
  logic aw_full_q, aw_full_d;
  logic w_full_q, w_full_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wake_q, wake_d;
  logic vector_q, vector_d;
  logic low_prev_q, low_prev_d;
  logic stable_now;
  logic low_ev;
  logic low_edge;
  logic stable_ev;
  logic do_write;
  logic do_read;
  logic [`LVD_EV_W-1:0] clr;

  assign awready = !aw_full_q && !bvalid_q;
  assign wready = !w_full_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign do_read = arvalid && arready;

  // reference counts as stable from its own indicator, or at once when the shared circuit keeps it running
  assign stable_now = ref_s2 || bor_s2;
  assign low_ev = (state_q == lvd_pkg::ST_ARMED) && low_s2;
  assign stable_ev = (state_q == lvd_pkg::ST_SETTLE) && stable_now && ctrl_q[`LVD_PWR_BIT];
  // a wake follows each crossing once, not every cycle the supply stays low
  assign low_edge = low_ev && !low_prev_q;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    gie_d = gie_q;
    clr = '0;
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && awready)
    begin
      aw_full_d = 1'b1;
      waddr_d = word_ofs(awaddr);
    end
    if (wvalid && wready)
    begin
      w_full_d = 1'b1;
      wdata_d = wdata;
      wstrb0_d = wstrb[0];
    end
    if (do_write)
    begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `LVD_RESP_OKAY;
      case (waddr_q)
        `LVD_OFF_CTRL:
        begin
          if (wstrb0_q)
          begin
            ctrl_d = wdata_q[4:0];
          end
        end
        `LVD_OFF_CLEAR:
        begin
          if (wstrb0_q)
          begin
            clr = wdata_q[`LVD_EV_W-1:0];
          end
        end
        `LVD_OFF_IRQ_EN:
        begin
          if (wstrb0_q)
          begin
            irq_en_d = wdata_q[`LVD_EV_W-1:0];
          end
        end
        `LVD_OFF_CORE:
        begin
          if (wstrb0_q)
          begin
            gie_d = wdata_q[`LVD_GIE_BIT];
          end
        end
        `LVD_OFF_STATUS:
        begin
          bresp_d = `LVD_RESP_OKAY;
        end
        default:
        begin
          bresp_d = `LVD_RESP_SLVERR;
        end
      endcase
    end
    else if (bvalid_q && bready)
    begin
      bvalid_d = 1'b0;
    end
    if (do_read)
    begin
      rvalid_d = 1'b1;
      rresp_d = `LVD_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (word_ofs(araddr))
        `LVD_OFF_CTRL:
        begin
          rdata_d[4:0] = ctrl_q;
          rdata_d[`LVD_STABLE_BIT] = (state_q == lvd_pkg::ST_ARMED);
        end
        `LVD_OFF_STATUS:
        begin
          rdata_d[`LVD_EV_W-1:0] = status_q;
        end
        `LVD_OFF_CLEAR:
        begin
          rdata_d = 32'h0000_0000;
        end
        `LVD_OFF_IRQ_EN:
        begin
          rdata_d[`LVD_EV_W-1:0] = irq_en_q;
        end
        `LVD_OFF_CORE:
        begin
          rdata_d[`LVD_GIE_BIT] = gie_q;
        end
        default:
        begin
          rresp_d = `LVD_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && rready)
    begin
      rvalid_d = 1'b0;
    end
    // a new event wins over a clear in the same cycle
    status_d = (status_q & ~clr) | {stable_ev, low_ev};
    actl_d = decode_ctrl(ctrl_d);
    low_prev_d = low_ev;
    wake_d = sleep_mode && low_edge;
    vector_d = sleep_mode && low_edge && gie_q;
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      lvd_pkg::ST_OFF:
      begin
        if (ctrl_q[`LVD_PWR_BIT])
        begin
          state_d = lvd_pkg::ST_SETTLE;
        end
      end
      lvd_pkg::ST_SETTLE:
      begin
        if (!ctrl_q[`LVD_PWR_BIT])
        begin
          state_d = lvd_pkg::ST_OFF;
        end
        else if (stable_now)
        begin
          state_d = lvd_pkg::ST_ARMED;
        end
      end
      lvd_pkg::ST_ARMED:
      begin
        if (!ctrl_q[`LVD_PWR_BIT])
        begin
          state_d = lvd_pkg::ST_OFF;
        end
        else if (!stable_now)
        begin
          state_d = lvd_pkg::ST_SETTLE;
        end
      end
      default:
      begin
        state_d = lvd_pkg::ST_OFF;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `LVD_CTRL_RESET;
      status_q <= '0;
      irq_en_q <= '0;
      gie_q <= 1'b0;
      state_q <= lvd_pkg::ST_OFF;
      actl_q <= decode_ctrl(`LVD_CTRL_RESET);
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      wake_q <= 1'b0;
      vector_q <= 1'b0;
      low_prev_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      status_q <= status_d;
      irq_en_q <= irq_en_d;
      gie_q <= gie_d;
      state_q <= state_d;
      actl_q <= actl_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      wake_q <= wake_d;
      vector_q <= vector_d;
      low_prev_q <= low_prev_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign analog_ctrl = actl_q;
  assign irq = |(status_q & irq_en_q);
  assign wake_request = wake_q;
  assign vector_branch = vector_q;

  // ****************************************
  // assertions
  // ****************************************
  property p_ext_sel;
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_q[3:0] == 4'hF) |-> (analog_ctrl.ext_sel && analog_ctrl.tap_sel == 15'h0000);
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("external input not selected");

  property p_tap4;
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_q[3:0] == 4'h4) |-> (!analog_ctrl.ext_sel && analog_ctrl.tap_sel == 15'h0010);
  endproperty
  a_tap4: assert property (p_tap4) else $error("code 4 tap wrong");

  property p_power;
    @(posedge aclk) disable iff (!aresetn)
    analog_ctrl.power_en == ctrl_q[`LVD_PWR_BIT];
  endproperty
  a_power: assert property (p_power) else $error("power enable not following control");

  property p_no_flag_unstable;
    @(posedge aclk) disable iff (!aresetn)
    (state_q != lvd_pkg::ST_ARMED && !status_q[0]) |=> !status_q[0];
  endproperty
  a_no_flag_unstable: assert property (p_no_flag_unstable) else $error("flag set before stable");

  sequence s_enable;
    $rose(ctrl_q[`LVD_PWR_BIT]);
  endsequence
  property p_settle_first;
    @(posedge aclk) disable iff (!aresetn)
    s_enable |-> ##1 (state_q == lvd_pkg::ST_SETTLE);
  endproperty
  a_settle_first: assert property (p_settle_first) else $error("enable skipped settling");

  property p_bor_fast;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == lvd_pkg::ST_SETTLE && bor_s2 && ctrl_q[`LVD_PWR_BIT]) |=> (state_q == lvd_pkg::ST_ARMED);
  endproperty
  a_bor_fast: assert property (p_bor_fast) else $error("running reference still settling");

  sequence s_sleep_trip;
    sleep_mode && state_q == lvd_pkg::ST_ARMED && low_s2 && !low_prev_q;
  endsequence
  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
    s_sleep_trip |=> (wake_request && status_q[0]);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on trip in sleep");

  property p_vector;
    @(posedge aclk) disable iff (!aresetn)
    wake_request |-> (vector_branch == $past(gie_q));
  endproperty
  a_vector: assert property (p_vector) else $error("vector branch disagrees with global enable");

  property p_reset_off;
    @(posedge aclk)
    !aresetn |=> (!analog_ctrl.power_en && state_q == lvd_pkg::ST_OFF && ctrl_q == `LVD_CTRL_RESET);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset left monitor on");

  property p_trip;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == lvd_pkg::ST_ARMED && low_s2) |=> status_q[0];
  endproperty
  a_trip: assert property (p_trip) else $error("trip did not set flag");

  property p_sync_delay;
    @(posedge aclk) disable iff (!aresetn)
    $rose(status_q[0]) |-> $past(sense.supply_low, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("flag set without synchronised cause");

endmodule // low_voltage_detect_control

// ### testbench/testbench.sv
// Purpose: self-checking bench of the low voltage monitor control block
// Assumes: aclk 200 MHz, aresetn synchronous active low, register map from lvd_cfg.svh
// Notes: inputs change by non-blocking assignment after a rising edge; waits have no timeout of their own, only the watchdog ends a hang
`timescale 1ns/1ps
`include "lvd_cfg.svh"

module testbench;
  logic aclk, aresetn, sleep_mode, irq, wake_request, vector_branch;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  lvd_pkg::analog_sense_t sense;
  lvd_pkg::analog_ctrl_t analog_ctrl;
  int n_mismatch = 0;
  int cmp_count = 0;
  int wake_n = 0;
  logic vec_q = 1'b0;

  low_voltage_detect_control low_voltage_detect_control_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sense(sense), .analog_ctrl(analog_ctrl), .sleep_mode(sleep_mode),
    .irq(irq), .wake_request(wake_request), .vector_branch(vector_branch)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // wake pulses last one cycle, so they are counted here
  always @(posedge aclk)
  begin
    if (wake_request === 1'b1)
    begin
      wake_n++;
      vec_q = vector_branch;
    end
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic lvd_pkg::analog_ctrl_t exp_ac(input logic [3:0] c, input logic p);
    lvd_pkg::analog_ctrl_t e;
    e.power_en = p;
    e.ext_sel = (c == `LVD_CODE_EXT);
    e.tap_sel = 15'h0000;
    if (c != `LVD_CODE_EXT && c != `LVD_CODE_RSVD)
      e.tap_sel[c] = 1'b1;
    return e;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_t && w_t))
    begin
      @(posedge aclk);
      aw_t = aw_t | awready;
      w_t = w_t | wready;
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, `LVD_RESP_OKAY);
    chk(d, e);
  endtask

  task automatic ac(input logic [3:0] c, input logic p);
    chk({15'h0000, analog_ctrl}, {15'h0000, exp_ac(c, p)});
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    logic [31:0] d;
    aresetn = 1'b0;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, sleep_mode} = '0;
    wstrb = 4'hF;
    sense = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ac(4'h5, 1'b0);
    rc(`LVD_OFF_CTRL, 32'h05);
    $display("test reset finished");
    for (int c = 0; c < 16; c++)
    begin
      wr(`LVD_OFF_CTRL, c, `LVD_RESP_OKAY);
      ac(c[3:0], 1'b0);
    end
    $display("test decode finished");
    wr(`LVD_OFF_CTRL, 32'h14, `LVD_RESP_OKAY);
    ac(4'h4, 1'b1);
    sense.supply_low <= 1'b1;
    repeat (200) @(posedge aclk);
    rc(`LVD_OFF_CTRL, 32'h14);
    rc(`LVD_OFF_STATUS, 32'h00);
    sense.supply_low <= 1'b0;
    sense.ref_stable <= 1'b1;
    repeat (6) @(posedge aclk);
    rc(`LVD_OFF_CTRL, 32'h34);
    rc(`LVD_OFF_STATUS, 32'h02);
    wr(`LVD_OFF_CLEAR, 32'h03, `LVD_RESP_OKAY);
    rc(`LVD_OFF_STATUS, 32'h00);
    $display("test settle finished");
    wr(`LVD_OFF_IRQ_EN, 32'h01, `LVD_RESP_OKAY);
    sense.supply_low <= 1'b1;
    repeat (6) @(posedge aclk);
    sense.supply_low <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(irq, 1'b1);
    rc(`LVD_OFF_STATUS, 32'h01);
    wr(`LVD_OFF_IRQ_EN, 32'h00, `LVD_RESP_OKAY);
    chk(irq, 1'b0);
    wr(`LVD_OFF_IRQ_EN, 32'h01, `LVD_RESP_OKAY);
    chk(irq, 1'b1);
    wr(`LVD_OFF_CLEAR, 32'h01, `LVD_RESP_OKAY);
    chk(irq, 1'b0);
    rc(`LVD_OFF_STATUS, 32'h00);
    $display("test interrupt finished");
    sleep_mode <= 1'b1;
    for (int g = 0; g < 2; g++)
    begin
      wr(`LVD_OFF_CORE, g, `LVD_RESP_OKAY);
      wake_n = 0;
      sense.supply_low <= 1'b1;
      repeat (6) @(posedge aclk);
      sense.supply_low <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(wake_n, 1);
      chk(vec_q, g[0]);
      rc(`LVD_OFF_STATUS, 32'h01);
      wr(`LVD_OFF_CLEAR, 32'h01, `LVD_RESP_OKAY);
    end
    sleep_mode <= 1'b0;
    $display("test sleep finished");
    wr(`LVD_OFF_CTRL, 32'h04, `LVD_RESP_OKAY);
    ac(4'h4, 1'b0);
    rc(`LVD_OFF_CTRL, 32'h04);
    sense.ref_stable <= 1'b0;
    sense.bor_ref_on <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(`LVD_OFF_CTRL, 32'h1F, `LVD_RESP_OKAY);
    repeat (6) @(posedge aclk);
    rc(`LVD_OFF_CTRL, 32'h3F);
    $display("test shared reference finished");
    rd(8'h14, d, `LVD_RESP_SLVERR);
    wr(8'h14, 32'h00, `LVD_RESP_SLVERR);
    wr(`LVD_OFF_STATUS, 32'h03, `LVD_RESP_OKAY);
    rc(`LVD_OFF_CLEAR, 32'h00);
    $display("test bus finished");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ac(4'h5, 1'b0);
    rc(`LVD_OFF_CTRL, 32'h05);
    $display("test second reset finished");
    summarize();
  end

  // the whole run needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end
endmodule // testbench
